//--- rtl/sfb_pkg.sv
package sfb_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DROP_AC_MS = 20;
    localparam int unsigned DROP_DC_MS = 10;
    // Longest dropout counts round down
    localparam int unsigned DROP_AC_CYCLES = DROP_AC_MS * (CLK_HZ / 1000);
    localparam int unsigned DROP_DC_CYCLES = DROP_DC_MS * (CLK_HZ / 1000);
    localparam int DROP_CNT_W = 20;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CLOCK0 = 8'h08;
    localparam logic [7:0] ADDR_CLOCK1 = 8'h0c;
    localparam logic [7:0] ADDR_CLOCK2 = 8'h10;
    localparam logic [7:0] ADDR_CLOCK3 = 8'h14;
    localparam logic [7:0] ADDR_WDT_CAUSE = 8'h18;

    localparam int FL_FUSE = 0;
    localparam int FL_DROP = 1;
    localparam int FL_BATLIVE = 2;
    localparam int FL_BATLATCH = 3;
    localparam int FL_SDIAG = 4;
    localparam int FL_DIAG = 5;
    localparam int FL_CLKERR = 6;
    localparam int FL_ONE = 7;
    localparam int FL_ZERO = 8;
    localparam int FL_WDT = 9;
    localparam int FL_READY = 10;
    localparam int FL_TEST = 11;
    localparam int FL_TESTERR = 12;
    localparam int FL_FSTOP = 13;
    localparam logic [15:0] FLAGS_RST = 16'h0080;
    // Flags that an error release clears
    localparam logic [15:0] FLAGS_RELEASABLE = 16'h1279;

    localparam int CT_CSET = 0;
    localparam int CT_CREAD = 1;
    localparam int CT_ERRREL = 2;
    localparam int CT_READY = 3;
    localparam int CT_BATEN = 4;
    localparam logic [7:0] CTRL_MASK = 8'h1f;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam int PN_FUSE = 0;
    localparam int PN_SUPPLY = 1;
    localparam int PN_ACSEL = 2;
    localparam int PN_BATT = 3;
    localparam int PN_SDIAG = 4;
    localparam int PN_DIAG = 5;
    localparam int PN_WDT = 6;
    localparam int PN_PARAM = 7;
    localparam int PN_TREQ = 8;
    localparam int PN_TOK = 9;
    localparam int PN_FSTOP = 10;
    localparam int PIN_W = 11;
    // Supply good and forced stop active out of reset: no false dropout, no false release
    localparam logic [10:0] PIN_RST = 11'h402;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/sfb_clk_if.sv
interface sfb_clk_if;
    logic setStb;
    logic [3:0][15:0] setWord;
    logic setErr;
    logic [3:0][15:0] curWord;
    modport ctl (output setStb, output setWord, input setErr, input curWord);
    modport elem (input setStb, input setWord, output setErr, output curWord);
endinterface

//--- rtl/sfb_clock_elem.sv
module sfb_clock_elem (
    input wire logic clk_sys,
    input wire logic rst,
    sfb_clk_if.elem clkIf
);
    typedef struct packed {
        logic [3:0][15:0] word;
        logic err;
    } sfb_elem_t;

    sfb_elem_t q;
    sfb_elem_t n;

    assign clkIf.curWord = q.word;
    assign clkIf.setErr = q.err;

    always_comb
    begin
        logic valid;
        valid = 1'b1;
        n = q;
        n.err = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            if (clkIf.setWord[i / 4][(i % 4) * 4 +: 4] > 4'h9)
            begin
                valid = 1'b0;
            end
        end
        if (clkIf.setStb)
        begin
            // Bad BCD leaves the held time untouched
            if (valid)
            begin
                n.word = clkIf.setWord;
            end
            else
            begin
                n.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end
endmodule

//--- rtl/sfb_flag_bank.sv
module sfb_flag_bank #(
    parameter int unsigned DROP_AC_CYCLES = sfb_pkg::DROP_AC_CYCLES,
    parameter int unsigned DROP_DC_CYCLES = sfb_pkg::DROP_DC_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fuseBlownIn,
    input wire logic supplyOkIn,
    input wire logic acSupplySel,
    input wire logic batteryLowIn,
    input wire logic selfDiagErrIn,
    input wire logic diagErrIn,
    input wire logic watchdogErrIn,
    input wire logic [7:0] watchdogCauseIn,
    input wire logic paramCheckOkIn,
    input wire logic testModeReqIn,
    input wire logic testModeOkIn,
    input wire logic forcedStopIn,
    output logic axisStopOut,
    output logic errorReleaseOut,
    output logic batteryLampOut
);
    typedef struct packed {
        logic [10:0] pinS1;
        logic [10:0] pinS2;
        logic [10:0] pinPrev;
        logic [7:0] causeS1;
        logic [7:0] causeS2;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] ctrl;
        logic [7:0] ctrlPrev;
        logic [3:0][15:0] clkWord;
        logic [7:0] wdtCause;
        logic [15:0] flags;
        logic [19:0] dropCnt;
        logic setStb;
        logic axisStop;
        logic errRel;
        logic lamp;
    } sfb_state_t;

    sfb_state_t q;
    sfb_state_t n;
    logic [10:0] pinRaw;
    logic errClr;
    sfb_clk_if clkIf ();

    sfb_clock_elem u_clock (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkIf(clkIf.elem)
    );

    assign pinRaw = {forcedStopIn, testModeOkIn, testModeReqIn, paramCheckOkIn,
        watchdogErrIn, diagErrIn, selfDiagErrIn, batteryLowIn, acSupplySel,
        supplyOkIn, fuseBlownIn};
    assign errClr = q.ctrl[sfb_pkg::CT_ERRREL] & ~q.ctrlPrev[sfb_pkg::CT_ERRREL];

    assign clkIf.setStb = q.setStb;
    assign clkIf.setWord = q.clkWord;

    assign s_axi_awready = q.awRdy;
    assign s_axi_wready = q.wRdy;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = q.arRdy;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;
    assign axisStopOut = q.axisStop;
    assign errorReleaseOut = q.errRel;
    assign batteryLampOut = q.lamp;

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                r[b * 8 +: 8] = wd[b * 8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb
    begin
        logic [10:0] pins;
        logic [10:0] rise;
        logic [7:0] ctlRise;
        logic [19:0] lim;
        logic [31:0] wv;
        pins = q.pinS2;
        rise = q.pinS2 & ~q.pinPrev;
        ctlRise = q.ctrl & ~q.ctrlPrev;
        lim = pins[sfb_pkg::PN_ACSEL] ? 20'(DROP_AC_CYCLES) : 20'(DROP_DC_CYCLES);
        wv = '0;
        n = q;
        n.pinS1 = pinRaw;
        n.pinS2 = q.pinS1;
        n.pinPrev = q.pinS2;
        n.causeS1 = watchdogCauseIn;
        n.causeS2 = q.causeS1;
        n.ctrlPrev = q.ctrl;
        // Clears first so that a coincident set wins
        n.errRel = errClr;
        if (errClr)
        begin
            n.flags = q.flags & ~sfb_pkg::FLAGS_RELEASABLE;
            n.axisStop = 1'b0;
        end
        n.flags[sfb_pkg::FL_ONE] = 1'b1;
        n.flags[sfb_pkg::FL_ZERO] = 1'b0;
        if (pins[sfb_pkg::PN_FUSE])
        begin
            n.flags[sfb_pkg::FL_FUSE] = 1'b1;
        end
        if (pins[sfb_pkg::PN_SDIAG])
        begin
            n.flags[sfb_pkg::FL_SDIAG] = 1'b1;
        end
        if (pins[sfb_pkg::PN_DIAG])
        begin
            n.flags[sfb_pkg::FL_DIAG] = 1'b1;
        end
        // Battery flags
        n.flags[sfb_pkg::FL_BATLIVE] = q.ctrl[sfb_pkg::CT_BATEN]
            & pins[sfb_pkg::PN_BATT];
        n.lamp = n.flags[sfb_pkg::FL_BATLIVE];
        if (n.flags[sfb_pkg::FL_BATLIVE])
        begin
            n.flags[sfb_pkg::FL_BATLATCH] = 1'b1;
        end
        // Dropout length; reset is the only way back to off
        if (!pins[sfb_pkg::PN_SUPPLY])
        begin
            if (q.dropCnt < lim)
            begin
                n.dropCnt = q.dropCnt + 20'h00001;
            end
        end
        else
        begin
            if (rise[sfb_pkg::PN_SUPPLY] && q.dropCnt < lim)
            begin
                n.flags[sfb_pkg::FL_DROP] = 1'b1;
            end
            n.dropCnt = '0;
        end
        // Watchdog
        if (pins[sfb_pkg::PN_WDT])
        begin
            n.flags[sfb_pkg::FL_WDT] = 1'b1;
            n.wdtCause = q.causeS2;
            n.axisStop = 1'b1;
        end
        // Ready handshake
        if (!q.ctrl[sfb_pkg::CT_READY])
        begin
            n.flags[sfb_pkg::FL_READY] = 1'b0;
        end
        else if (ctlRise[sfb_pkg::CT_READY])
        begin
            n.flags[sfb_pkg::FL_READY] = pins[sfb_pkg::PN_PARAM];
        end
        // Test mode
        if (!pins[sfb_pkg::PN_TREQ])
        begin
            n.flags[sfb_pkg::FL_TEST] = 1'b0;
        end
        else if (rise[sfb_pkg::PN_TREQ])
        begin
            if (pins[sfb_pkg::PN_TOK])
            begin
                n.flags[sfb_pkg::FL_TEST] = 1'b1;
            end
            else
            begin
                n.flags[sfb_pkg::FL_TESTERR] = 1'b1;
            end
        end
        n.flags[sfb_pkg::FL_FSTOP] = ~pins[sfb_pkg::PN_FSTOP];
        // Clock element
        n.setStb = ctlRise[sfb_pkg::CT_CSET];
        if (clkIf.setErr)
        begin
            n.flags[sfb_pkg::FL_CLKERR] = 1'b1;
        end
        if (q.ctrl[sfb_pkg::CT_CREAD])
        begin
            n.clkWord = clkIf.curWord;
        end
        // Write channel
        if (q.bValid && s_axi_bready)
        begin
            n.bValid = 1'b0;
        end
        if (s_axi_awvalid && q.awRdy)
        begin
            n.awHeld = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wRdy)
        begin
            n.wHeld = 1'b1;
            n.wData = s_axi_wdata;
            n.wStrb = s_axi_wstrb;
        end
        if (q.awHeld && q.wHeld && !q.bValid)
        begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bValid = 1'b1;
            n.bResp = sfb_pkg::RESP_OKAY;
            case (q.awAddr)
                sfb_pkg::ADDR_CONTROL:
                begin
                    wv = merge({24'h000000, q.ctrl}, q.wData, q.wStrb);
                    n.ctrl = wv[7:0] & sfb_pkg::CTRL_MASK;
                end
                sfb_pkg::ADDR_CLOCK0, sfb_pkg::ADDR_CLOCK1,
                sfb_pkg::ADDR_CLOCK2, sfb_pkg::ADDR_CLOCK3:
                begin
                    // Hardware load wins while a read request is held
                    if (!q.ctrl[sfb_pkg::CT_CREAD])
                    begin
                        wv = merge({16'h0000, q.clkWord[q.awAddr[4:2] - 3'h2]},
                            q.wData, q.wStrb);
                        n.clkWord[q.awAddr[4:2] - 3'h2] = wv[15:0];
                    end
                end
                sfb_pkg::ADDR_STATUS, sfb_pkg::ADDR_WDT_CAUSE:
                begin
                    n.bResp = sfb_pkg::RESP_OKAY;
                end
                default:
                begin
                    n.bResp = sfb_pkg::RESP_SLVERR;
                end
            endcase
        end
        n.awRdy = !n.awHeld && !n.bValid;
        n.wRdy = !n.wHeld && !n.bValid;
        // Read channel
        if (q.rValid && s_axi_rready)
        begin
            n.rValid = 1'b0;
        end
        if (s_axi_arvalid && q.arRdy)
        begin
            n.rValid = 1'b1;
            n.rResp = sfb_pkg::RESP_OKAY;
            n.rData = '0;
            case (s_axi_araddr)
                sfb_pkg::ADDR_STATUS: n.rData = {16'h0000, q.flags};
                sfb_pkg::ADDR_CONTROL: n.rData = {24'h000000, q.ctrl};
                sfb_pkg::ADDR_CLOCK0: n.rData = {16'h0000, q.clkWord[0]};
                sfb_pkg::ADDR_CLOCK1: n.rData = {16'h0000, q.clkWord[1]};
                sfb_pkg::ADDR_CLOCK2: n.rData = {16'h0000, q.clkWord[2]};
                sfb_pkg::ADDR_CLOCK3: n.rData = {16'h0000, q.clkWord[3]};
                sfb_pkg::ADDR_WDT_CAUSE: n.rData = {24'h000000, q.wdtCause};
                default: n.rResp = sfb_pkg::RESP_SLVERR;
            endcase
        end
        n.arRdy = !n.rValid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
            q.flags <= sfb_pkg::FLAGS_RST;
            q.ctrl <= sfb_pkg::CTRL_RST;
            q.pinS1 <= sfb_pkg::PIN_RST;
            q.pinS2 <= sfb_pkg::PIN_RST;
            q.pinPrev <= sfb_pkg::PIN_RST;
        end
        else
        begin
            q <= n;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_const_pair: assert property (q.flags[sfb_pkg::FL_ONE] && !q.flags[sfb_pkg::FL_ZERO])
        else $error("constant flags wrong");
    a_fuse_sticky: assert property (q.pinS2[sfb_pkg::PN_FUSE] ##1 !errClr [*3]
        |-> q.flags[sfb_pkg::FL_FUSE])
        else $error("fuse flag not held");
    a_drop_held: assert property ($past(q.flags[sfb_pkg::FL_DROP]) |-> q.flags[sfb_pkg::FL_DROP])
        else $error("dropout flag cleared without reset");
    a_batt_gate: assert property (!q.ctrl[sfb_pkg::CT_BATEN]
        |=> !q.flags[sfb_pkg::FL_BATLIVE] && !batteryLampOut)
        else $error("battery flag without enable");
    a_batt_latch: assert property (q.flags[sfb_pkg::FL_BATLIVE] && !errClr
        |=> q.flags[sfb_pkg::FL_BATLATCH])
        else $error("battery latch missed");
    a_wdt_stop: assert property (q.pinS2[sfb_pkg::PN_WDT]
        |=> axisStopOut && q.flags[sfb_pkg::FL_WDT] && q.wdtCause == $past(q.causeS2))
        else $error("watchdog did not stop axes");
    a_ready_drop: assert property (!q.ctrl[sfb_pkg::CT_READY] |=> !q.flags[sfb_pkg::FL_READY])
        else $error("ready flag stayed on");
    a_test_refused: assert property ($rose(q.pinS2[sfb_pkg::PN_TREQ]) && !q.pinS2[sfb_pkg::PN_TOK]
        |=> q.flags[sfb_pkg::FL_TESTERR] && !q.flags[sfb_pkg::FL_TEST])
        else $error("refused test request not flagged");
    a_fstop_invert: assert property (1'b1 |=> q.flags[sfb_pkg::FL_FSTOP]
        != $past(q.pinS2[sfb_pkg::PN_FSTOP]))
        else $error("forced stop flag sense wrong");
    a_clkset_once: assert property ($rose(q.ctrl[sfb_pkg::CT_CSET]) |=> q.setStb ##1 !q.setStb)
        else $error("clock set strobe wrong");
    a_release_pulse: assert property ($rose(q.ctrl[sfb_pkg::CT_ERRREL]) |=> errorReleaseOut
        ##1 !errorReleaseOut)
        else $error("error release pulse wrong");
endmodule

//--- test/tb_system_status_flag_bank.sv
module tb_system_status_flag_bank;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic fuseBlownIn = 1'b0, supplyOkIn = 1'b1, acSupplySel = 1'b1, batteryLowIn = 1'b0;
    logic selfDiagErrIn = 1'b0, diagErrIn = 1'b0, watchdogErrIn = 1'b0;
    logic paramCheckOkIn = 1'b0, testModeReqIn = 1'b0, testModeOkIn = 1'b0;
    // Forced stop held active through reset so the status word reads its reset value
    logic forcedStopIn = 1'b1;
    logic [7:0] watchdogCauseIn = 8'h00;
    logic axisStopOut, errorReleaseOut, batteryLampOut;
    logic [31:0] rd;
    logic [1:0] rsp;
    int mismatches = 0;
    int samplesChecked = 0;
    int relCount = 0;

    // Short dropout limits keep the run brief
    sfb_flag_bank #(.DROP_AC_CYCLES(40), .DROP_DC_CYCLES(20)) u_sfb_flag_bank (
        .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fuseBlownIn, .supplyOkIn,
        .acSupplySel, .batteryLowIn, .selfDiagErrIn, .diagErrIn, .watchdogErrIn,
        .watchdogCauseIn, .paramCheckOkIn, .testModeReqIn, .testModeOkIn, .forcedStopIn,
        .axisStopOut, .errorReleaseOut, .batteryLampOut
    );

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    // The release pulse lasts one cycle, so it is counted rather than polled
    always @(posedge clk_sys)
    begin
        if (errorReleaseOut === 1'b1)
            relCount++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        samplesChecked++;
        if (seen !== expv)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdReg(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic flag(input int k, input logic e);
        rdReg(sfb_pkg::ADDR_STATUS);
        check({31'h0, rd[k]}, {31'h0, e});
    endtask

    task automatic ctl(input logic [7:0] v);
        wr(sfb_pkg::ADDR_CONTROL, {24'h0, v});
    endtask

    task automatic dropout(input int n);
        supplyOkIn <= 1'b0;
        idle(n);
        supplyOkIn <= 1'b1;
        idle(8);
    endtask

    initial
    begin
        idle(20000);
        mismatches++;
        end_of_test();
    end

    initial
    begin
        idle(4);
        rst <= 1'b0;
        idle(1);
        rdReg(sfb_pkg::ADDR_STATUS);
        check(rd, 32'h0000_0080);
        rdReg(sfb_pkg::ADDR_CONTROL);
        check(rd, 32'h0);
        wr(sfb_pkg::ADDR_STATUS, 32'hffff_ffff);
        check({30'h0, rsp}, {30'h0, sfb_pkg::RESP_OKAY});
        rdReg(sfb_pkg::ADDR_STATUS);
        check(rd, 32'h0000_0080);
        rdReg(8'h1c);
        check({30'h0, rsp}, {30'h0, sfb_pkg::RESP_SLVERR});
        check(rd, 32'h0);
        wr(8'h1c, 32'hffff_ffff);
        check({30'h0, rsp}, {30'h0, sfb_pkg::RESP_SLVERR});
        forcedStopIn <= 1'b0;
        idle(8);
        flag(sfb_pkg::FL_FSTOP, 1'b1);
        forcedStopIn <= 1'b1;
        idle(8);
        flag(sfb_pkg::FL_FSTOP, 1'b0);
        forcedStopIn <= 1'b0;
        fuseBlownIn <= 1'b1;
        selfDiagErrIn <= 1'b1;
        diagErrIn <= 1'b1;
        watchdogCauseIn <= 8'h5a;
        watchdogErrIn <= 1'b1;
        idle(8);
        fuseBlownIn <= 1'b0;
        selfDiagErrIn <= 1'b0;
        diagErrIn <= 1'b0;
        watchdogErrIn <= 1'b0;
        idle(8);
        flag(sfb_pkg::FL_FUSE, 1'b1);
        flag(sfb_pkg::FL_SDIAG, 1'b1);
        flag(sfb_pkg::FL_DIAG, 1'b1);
        flag(sfb_pkg::FL_WDT, 1'b1);
        rdReg(sfb_pkg::ADDR_WDT_CAUSE);
        check(rd, 32'h0000_005a);
        check({31'h0, axisStopOut}, 32'h1);
        batteryLowIn <= 1'b1;
        idle(8);
        flag(sfb_pkg::FL_BATLIVE, 1'b0);
        flag(sfb_pkg::FL_BATLATCH, 1'b0);
        ctl(8'h10);
        idle(8);
        flag(sfb_pkg::FL_BATLIVE, 1'b1);
        check({31'h0, batteryLampOut}, 32'h1);
        batteryLowIn <= 1'b0;
        idle(8);
        flag(sfb_pkg::FL_BATLIVE, 1'b0);
        flag(sfb_pkg::FL_BATLATCH, 1'b1);
        ctl(8'h14);
        idle(4);
        check(relCount, 32'h1);
        flag(sfb_pkg::FL_FUSE, 1'b0);
        flag(sfb_pkg::FL_WDT, 1'b0);
        flag(sfb_pkg::FL_BATLATCH, 1'b0);
        check({31'h0, axisStopOut}, 32'h0);
        ctl(8'h14);
        idle(4);
        check(relCount, 32'h1);
        ctl(8'h10);
        for (int i = 0; i < 4; i++)
            wr(sfb_pkg::ADDR_CLOCK0 + 8'(4 * i), 32'h1230 + i);
        ctl(8'h11);
        idle(4);
        for (int i = 0; i < 4; i++)
            wr(sfb_pkg::ADDR_CLOCK0 + 8'(4 * i), 32'h0990 + i);
        // A held set request must not store the new words
        ctl(8'h11);
        ctl(8'h13);
        idle(4);
        for (int i = 0; i < 4; i++)
        begin
            rdReg(sfb_pkg::ADDR_CLOCK0 + 8'(4 * i));
            check(rd, 32'h1230 + i);
        end
        ctl(8'h10);
        flag(sfb_pkg::FL_CLKERR, 1'b0);
        wr(sfb_pkg::ADDR_CLOCK0, 32'h00a0);
        ctl(8'h11);
        idle(6);
        flag(sfb_pkg::FL_CLKERR, 1'b1);
        ctl(8'h10);
        paramCheckOkIn <= 1'b1;
        idle(4);
        ctl(8'h18);
        idle(4);
        flag(sfb_pkg::FL_READY, 1'b1);
        ctl(8'h10);
        idle(2);
        flag(sfb_pkg::FL_READY, 1'b0);
        paramCheckOkIn <= 1'b0;
        idle(4);
        ctl(8'h18);
        idle(4);
        flag(sfb_pkg::FL_READY, 1'b0);
        ctl(8'h10);
        testModeOkIn <= 1'b1;
        testModeReqIn <= 1'b1;
        idle(8);
        flag(sfb_pkg::FL_TEST, 1'b1);
        testModeReqIn <= 1'b0;
        idle(8);
        flag(sfb_pkg::FL_TEST, 1'b0);
        testModeOkIn <= 1'b0;
        testModeReqIn <= 1'b1;
        idle(8);
        flag(sfb_pkg::FL_TESTERR, 1'b1);
        flag(sfb_pkg::FL_TEST, 1'b0);
        testModeReqIn <= 1'b0;
        dropout(10);
        flag(sfb_pkg::FL_DROP, 1'b1);
        ctl(8'h14);
        idle(4);
        flag(sfb_pkg::FL_DROP, 1'b1);
        rst <= 1'b1;
        idle(4);
        rst <= 1'b0;
        acSupplySel <= 1'b0;
        idle(4);
        flag(sfb_pkg::FL_DROP, 1'b0);
        // An outage longer than the limit is a real power loss, not a dropout
        dropout(30);
        flag(sfb_pkg::FL_DROP, 1'b0);
        dropout(10);
        flag(sfb_pkg::FL_DROP, 1'b1);
        end_of_test();
    end
endmodule
